// ### uart_tx_baud_rate_generator_bench.sv
`timescale 1ns/1ps
`default_nettype none
module uart_tx_baud_rate_generator_bench;
  import ubg_pkg::*;
  logic CLK, RST, HSEL, HWRITE, HREADYOUT, HRESP, TXD, RXD, txd_l, o;
  logic [31:0] HADDR, HWDATA, HRDATA, rd;
  logic [1:0] HTRANS;
  logic [19:0] per_r;
  logic [7:0] rx_byte, bq[$], rxq[$];
  logic [15:0] rx_count;
  int fail_count, samples_checked, seed, cyc, k, p, eq[$];
  ubg_top uut (.CLK(CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .TXD(TXD), .RXD(RXD));
  ubg_peer peer (.clk(CLK), .txd(TXD), .rxd(RXD), .period(per_r), .rx_byte(rx_byte),
    .rx_count(rx_count));
  // Source clock
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  // Cycle count, line edge times and bytes seen by the peer
  always @(negedge CLK) begin
    cyc++;
    if (TXD !== txd_l) eq.push_back(cyc);
    txd_l = TXD;
  end
  always @(rx_count) rxq.push_back(rx_byte);
  task check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // One single transfer; read data left in rd
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    logic r;
    {HSEL, HADDR, HTRANS, HWRITE} <= {1'b1, 24'h0, a, 2'h2, w};
    for (int ph = 0; ph < 2; ph++) begin
      do begin
        @(negedge CLK);
        r = HREADYOUT;
        rd = HRDATA;
        @(posedge CLK);
      end while (r !== 1'b1);
      if (ph == 0) {HSEL, HTRANS, HWDATA} <= {1'b0, 2'h0, wd};
    end
  endtask
  // Length of bit i of a frame in source clocks
  function automatic int bper(logic os, int p, int f, logic [7:0] s, int i);
    return os ? 16 * p + f + s[7 - i % 8] : p + s[7 - i % 8];
  endfunction
  // Poll status until the buffer takes a word
  task poll;
    k = 0;
    do begin
      bus(1'b0, ADDR_STATUS, 32'h0);
      k++;
    end while (rd[0] !== 1'b1 && k < 300);
  endtask
  // Send 0x55 so each bit boundary is an edge, then time the start bit and all eight data bits
  task frame(input logic os, input int p, input int f, input logic [7:0] s);
    per_r = 20'(os ? 16 * p + f : p);
    bus(1'b1, ADDR_BAUD, {s, 4'h0, f[3:0], p[15:0]});
    bus(1'b1, ADDR_CTRL, {30'h0, os, 1'b0});
    eq.delete();
    bus(1'b1, ADDR_TXBUF, 32'h55);
    bus(1'b0, ADDR_STATUS, 32'h0);
    check(rd[1:0], 2'h2);
    k = 0;
    while (eq.size() < 10 && k < 9000) begin
      @(posedge CLK);
      k++;
    end
    for (int i = 0; i < 9; i++) begin
      check(eq[i + 1] - eq[i], bper(os, p, f, s, i));
    end
    repeat (2 * bper(os, p, f, s, 1) + 4) @(posedge CLK);
    bus(1'b0, ADDR_STATUS, 32'h0);
    check(rd[1:0], 2'h1);
    check(TXD, 1'b1);
  endtask
  // Main sequence
  initial begin
    {HSEL, HWRITE, HTRANS, HADDR, HWDATA} = '0;
    RST = 1'b1;
    txd_l = 1'b1;
    per_r = 20'h0000C;
    fail_count = 0;
    samples_checked = 0;
    seed = 15537;
    repeat (10) @(posedge CLK);
    RST <= 1'b0;
    repeat (2) @(posedge CLK);
    bus(1'b0, ADDR_CTRL, 32'h0);
    check(rd, CTRL_RESET);
    bus(1'b0, ADDR_BAUD, 32'h0);
    check(rd, BAUD_RESET);
    bus(1'b1, ADDR_TXBUF, 32'hA5);
    bus(1'b1, 8'h10, 32'hFFFFFFFF);
    bus(1'b0, 8'h10, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, ADDR_STATUS, 32'h0);
    check(rd[1:0], 2'h1);
    frame(1'b0, 12, 0, 8'h00);
    check(rd[15:8], 8'hAA);
    frame(1'b0, 3, 0, 8'hFF);
    frame(1'b1, 1, 15, 8'h35);
    frame(1'b1, 2, 5, 8'h55);
    for (int n = 0; n < 4; n++) begin
      o = 1'($random(seed));
      p = o ? 1 + {$random(seed)} % 4 : 3 + {$random(seed)} % 14;
      frame(o, p, {$random(seed)} % 16, 8'($random(seed)));
    end
    // Random words back to back through the peer, direct mode, once the peer is quiet
    repeat (1000) @(posedge CLK);
    bus(1'b1, ADDR_CTRL, 32'h0);
    p = 3 + {$random(seed)} % 8;
    per_r = 20'(p);
    bus(1'b1, ADDR_BAUD, p);
    rxq.delete();
    eq.delete();
    for (int j = 0; j < 3; j++) begin
      bq.push_back(8'($random(seed)));
      bus(1'b1, ADDR_TXBUF, {24'h0, bq[j]});
      poll;
    end
    k = 0;
    while (rxq.size() < 3 && k < 2000) begin
      @(posedge CLK);
      k++;
    end
    for (int j = 0; j < 3; j++) check(rxq[j], bq[j]);
    for (int j = 1; j < 3; j++) begin
      k = 0;
      foreach (eq[i]) if (eq[i] == eq[0] + 10 * p * j) k = 1;
      check(k, 1);
    end
    // Soft reset in mid-frame
    bus(1'b1, ADDR_TXBUF, 32'h0);
    repeat (20) @(posedge CLK);
    bus(1'b1, ADDR_CTRL, 32'h1);
    repeat (3) @(posedge CLK);
    bus(1'b0, ADDR_STATUS, 32'h0);
    check(rd[1:0], 2'h1);
    check(TXD, 1'b1);
    end_sim;
  end
  // Watchdog
  initial begin
    repeat (60000) @(posedge CLK);
    fail_count++;
    end_sim;
  end
endmodule
`default_nettype wire

// ### ubg_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ubg_chk
  import ubg_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Bus
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  // Line
  input wire logic TXD
);
  logic ap_r, wr_r, srst_r, os_r, txd_r;
  logic [7:0] a_r;
  logic [15:0] pre_r;
  logic [19:0] len_r;
  wire ap = HSEL & HTRANS[1] & HREADY;
  wire wd = ap_r & wr_r;
  // Shadow of the bus phase and the control fields
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ap_r <= 1'b0;
      wr_r <= 1'b0;
      a_r <= 8'h00;
      {os_r, srst_r} <= 2'h1;
      pre_r <= 16'h0000;
    end else begin
      ap_r <= ap;
      wr_r <= HWRITE;
      a_r <= HADDR[7:0];
      if (wd && a_r == ADDR_CTRL) {os_r, srst_r} <= HWDATA[1:0];
      if (wd && a_r == ADDR_BAUD) pre_r <= HWDATA[15:0];
    end
  end
  // Cycles the line has held its level, saturating
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      txd_r <= 1'b1;
      len_r <= 20'hFFFFF;
    end else begin
      txd_r <= TXD;
      len_r <= (TXD != txd_r) ? 20'h00001 : len_r + {19'h00000, len_r != 20'hFFFFF};
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_rd(logic [7:0] a); ap_r && !wr_r && a_r == a; endsequence
  sequence s_edge; TXD != txd_r && !srst_r; endsequence
  property p_resp; HRESP == 1'b0; endproperty
  property p_rdy; !$past(RST) |-> HREADYOUT; endproperty
  property p_hold; !$past(ap && !HWRITE) |-> $stable(HRDATA); endproperty
  property p_ctrl; s_rd(ADDR_CTRL) |-> HRDATA[1:0] == {os_r, srst_r}; endproperty
  property p_unmap; ap_r && !wr_r && a_r > ADDR_STATUS |-> HRDATA == 32'h0; endproperty
  property p_srst; srst_r [*3] |-> TXD; endproperty
  property p_lf; s_edge ##0 !os_r |-> len_r >= {4'h0, pre_r}; endproperty
  property p_os; s_edge ##0 os_r |-> len_r >= {pre_r, 4'h0}; endproperty
  a_resp: assert property (p_resp) else $error("bus response not okay");
  a_rdy: assert property (p_rdy) else $error("bus not ready");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_ctrl: assert property (p_ctrl) else $error("control readback wrong");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_srst: assert property (p_srst) else $error("line active in soft reset");
  a_lf: assert property (p_lf) else $error("direct bit too short");
  a_os: assert property (p_os) else $error("oversampled bit too short");
endmodule
bind ubg_top ubg_chk u_chk (.CLK(CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
  .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .TXD(TXD));
`default_nettype wire

// ### ubg_gen.sv
`timescale 1ns/1ps
`default_nettype none
module ubg_gen
  import ubg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire logic restart,
  input wire ubg_pkg::ubg_cfg_t cfg,
  // Timing outputs
  output logic bit_tick,
  output logic x16_tick,
  output ubg_pkg::ubg_smp_t smp
);
  logic [16:0] cnt_r;
  logic [3:0] sub_r;
  logic [2:0] idx_r;
  logic m_bit;
  logic f_bit;
  logic [16:0] per_lf;
  logic [16:0] per_16;
  logic [16:0] mid_lf;

  // Period in source clocks, never below one
  function automatic logic [16:0] per_of(input logic [15:0] p, input logic a, input logic b);
    logic [16:0] s;
    s = {1'b0, p} + {16'h0000, a} + {16'h0000, b};
    per_of = (s == 17'h00000) ? 17'h00001 : s;
  endfunction

  // Modulation bits: second stage MSB first, first stage j < field
  always_comb begin
    m_bit = cfg.brs[3'h7 - idx_r];
    f_bit = (sub_r < cfg.brf);
    per_lf = per_of(cfg.presc, m_bit, 1'b0);
    per_16 = per_of(cfg.presc, f_bit, (sub_r == X16_LAST) & m_bit);
    mid_lf = per_lf >> 1;
  end

  // Period ends and sample strobes
  always_comb begin
    if (!cfg.os16) begin
      x16_tick = 1'b0;
      bit_tick = run & (cnt_r == per_lf - 17'h00001);
      smp.first = run & (cnt_r == mid_lf - 17'h00001);
      smp.mid = run & (cnt_r == mid_lf);
      smp.last = run & (cnt_r == mid_lf + 17'h00001);
    end else begin
      x16_tick = run & (cnt_r == per_16 - 17'h00001);
      bit_tick = x16_tick & (sub_r == X16_LAST);
      smp.first = x16_tick & (sub_r == X16_SMP_FIRST);
      smp.mid = x16_tick & (sub_r == X16_SMP_MID);
      smp.last = x16_tick & (sub_r == X16_SMP_LAST);
    end
  end

  // Source clock counter, held clear while stopped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 17'h00000;
    end else if (!run) begin
      cnt_r <= 17'h00000;
    end else if (bit_tick | x16_tick) begin
      cnt_r <= 17'h00000;
    end else begin
      cnt_r <= cnt_r + 17'h00001;
    end
  end

  // Sixteen-times step counter, restarts with each bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sub_r <= 4'h0;
    end else if (!run) begin
      sub_r <= 4'h0;
    end else if (x16_tick) begin
      sub_r <= sub_r + 4'h1;
    end
  end

  // Pattern index, wraps after eight and restarts at start bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idx_r <= 3'h0;
    end else if (!run) begin
      idx_r <= 3'h0;
    end else if (bit_tick) begin
      idx_r <= restart ? 3'h0 : idx_r + 3'h1;
    end
  end
endmodule
`default_nettype wire

// ### ubg_peer.sv
`timescale 1ns/1ps
`default_nettype none
module ubg_peer (
  // Line
  input wire logic clk,
  input wire logic txd,
  output logic rxd,
  // Decoder
  input wire logic [19:0] period,
  output logic [7:0] rx_byte,
  output logic [15:0] rx_count
);
  logic [7:0] sh;
  // Echo the line back one clock late
  always @(posedge clk) rxd <= txd;
  // Take frames mid-bit, keep those with a high stop bit
  initial begin
    rxd = 1'b1;
    rx_count = 16'h0000;
    forever begin
      @(negedge txd);
      repeat (period >> 1) @(negedge clk);
      repeat (8) begin
        repeat (period) @(negedge clk);
        sh = {txd, sh[7:1]};
      end
      repeat (period) @(negedge clk);
      if (txd === 1'b1) begin
        rx_byte = sh;
        rx_count = rx_count + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// ### ubg_pkg.sv
package ubg_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_BAUD = 8'h04;
  localparam logic [7:0] ADDR_TXBUF = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;

  // Field positions
  localparam int CTRL_SRST_BIT = 0;
  localparam int CTRL_OS16_BIT = 1;
  localparam int BAUD_PRE_LSB = 0;
  localparam int BAUD_BRF_LSB = 16;
  localparam int BAUD_BRS_LSB = 24;
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_MON_LSB = 8;

  // Values after reset
  localparam logic [31:0] CTRL_RESET = 32'h00000001;
  localparam logic [31:0] BAUD_RESET = 32'h00000000;

  // Counts
  localparam logic [3:0] FRAME_TAIL_BITS = 4'h9;
  localparam logic [3:0] X16_LAST = 4'hF;
  localparam logic [3:0] X16_SMP_FIRST = 4'h6;
  localparam logic [3:0] X16_SMP_MID = 4'h7;
  localparam logic [3:0] X16_SMP_LAST = 4'h8;

  // AHB-Lite transfer type bit for NONSEQ/SEQ
  localparam int HTRANS_ACTIVE_BIT = 1;

  // Generator configuration
  typedef struct packed {
    logic os16;
    logic [15:0] presc;
    logic [3:0] brf;
    logic [7:0] brs;
  } ubg_cfg_t;

  // Three sample strobes of one bit
  typedef struct packed {
    logic first;
    logic mid;
    logic last;
  } ubg_smp_t;

  typedef enum logic [3:0] {
    ST_OFF = 4'b0001,
    ST_IDLE = 4'b0010,
    ST_LOAD = 4'b0100,
    ST_SEND = 4'b1000
  } ubg_state_t;

  // Majority of three samples
  function automatic logic ubg_major(input logic a, input logic b, input logic c);
    ubg_major = (a & b) | (a & c) | (b & c);
  endfunction

endpackage

// ### ubg_top.sv
`timescale 1ns/1ps
`default_nettype none
module ubg_top
  import ubg_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Serial line
  output logic TXD,
  input wire logic RXD
);
  import ubg_pkg::*;

  ubg_state_t state_r;
  ubg_state_t state_nxt;
  logic [31:0] ctrl_r;
  logic [31:0] baud_r;
  logic [7:0] buf_r;
  logic buf_full_r;
  logic [8:0] shift_r;
  logic [3:0] left_r;
  logic txd_r;
  logic [7:0] mon_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  logic hresp_r;
  logic wr_pend_r;
  logic [7:0] waddr_r;
  logic rx_meta_r;
  logic rx_sync_r;
  logic port_soft_reset;
  logic oversample_select;
  ubg_cfg_t cfg;
  ubg_smp_t smp;
  logic bit_clock;
  logic bit_clock_x16;
  logic gen_run;
  logic load;
  logic frame_end;
  logic addr_ok;
  logic wr_buf;
  logic voted;
  logic vote_valid;
  logic [31:0] rd_val;

  // Control fields and generator configuration
  assign port_soft_reset = ctrl_r[CTRL_SRST_BIT];
  assign oversample_select = ctrl_r[CTRL_OS16_BIT];
  assign cfg.os16 = oversample_select;
  assign cfg.presc = baud_r[BAUD_PRE_LSB +: 16];
  assign cfg.brf = baud_r[BAUD_BRF_LSB +: 4];
  assign cfg.brs = baud_r[BAUD_BRS_LSB +: 8];

  // Bus request qualification
  assign addr_ok = HSEL & HTRANS[HTRANS_ACTIVE_BIT] & HREADY;
  assign wr_buf = wr_pend_r & (waddr_r == ADDR_TXBUF) & ~port_soft_reset;

  // Transmit events
  assign gen_run = (state_r == ST_LOAD) | (state_r == ST_SEND);
  assign frame_end = (state_r == ST_SEND) & bit_clock & (left_r == 4'h0);
  assign load = bit_clock & ((state_r == ST_LOAD) | (frame_end & buf_full_r));

  // Bit clock generator
  ubg_gen u_gen (
    .clk(CLK),
    .rst(RST),
    .run(gen_run),
    .restart(load),
    .cfg(cfg),
    .bit_tick(bit_clock),
    .x16_tick(bit_clock_x16),
    .smp(smp)
  );

  // Majority vote of the line during each bit
  ubg_vote u_vote (
    .clk(CLK),
    .rst(RST),
    .line(rx_sync_r),
    .smp(smp),
    .voted(voted),
    .valid(vote_valid)
  );

  // Two-stage synchroniser for the line input
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
    end else begin
      rx_meta_r <= RXD;
      rx_sync_r <= rx_meta_r;
    end
  end

  // Transmit state machine next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_OFF: begin
        if (!port_soft_reset) state_nxt = ST_IDLE;
      end
      ST_IDLE: begin
        if (wr_buf) state_nxt = ST_LOAD;
      end
      ST_LOAD: begin
        if (load) state_nxt = ST_SEND;
      end
      ST_SEND: begin
        if (frame_end && !buf_full_r) state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
    if (port_soft_reset) state_nxt = ST_OFF;
  end

  // Transmit state register
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_r <= ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Transmit buffer; a write in the load cycle keeps the buffer full
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      buf_r <= 8'h00;
      buf_full_r <= 1'b0;
    end else if (port_soft_reset) begin
      buf_full_r <= 1'b0;
    end else if (wr_buf) begin
      buf_r <= HWDATA[7:0];
      buf_full_r <= 1'b1;
    end else if (load) begin
      buf_full_r <= 1'b0;
    end
  end

  // Shift register and line driver
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      shift_r <= 9'h1FF;
      left_r <= 4'h0;
      txd_r <= 1'b1;
    end else if (port_soft_reset) begin
      shift_r <= 9'h1FF;
      left_r <= 4'h0;
      txd_r <= 1'b1;
    end else if (load) begin
      shift_r <= {1'b1, buf_r};
      left_r <= FRAME_TAIL_BITS;
      txd_r <= 1'b0;
    end else if (frame_end) begin
      txd_r <= 1'b1;
    end else if ((state_r == ST_SEND) && bit_clock) begin
      txd_r <= shift_r[0];
      shift_r <= {1'b1, shift_r[8:1]};
      left_r <= left_r - 4'h1;
    end
  end

  // Monitor byte of voted line bits, newest in the top bit
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      mon_r <= 8'hFF;
    end else if (vote_valid) begin
      mon_r <= {voted, mon_r[7:1]};
    end
  end

  // Write-side address phase capture
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wr_pend_r <= 1'b0;
      waddr_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_ok & HWRITE;
      if (addr_ok) waddr_r <= HADDR[7:0];
    end
  end

  // Control and baud registers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_r <= CTRL_RESET;
      baud_r <= BAUD_RESET;
    end else if (wr_pend_r) begin
      if (waddr_r == ADDR_CTRL) begin
        ctrl_r <= {30'h00000000, HWDATA[CTRL_OS16_BIT], HWDATA[CTRL_SRST_BIT]};
      end
      if (waddr_r == ADDR_BAUD) begin
        baud_r <= {HWDATA[31:24], 4'h0, HWDATA[19:16], HWDATA[15:0]};
      end
    end
  end

  // Read multiplexer; unmapped offsets read zero
  always_comb begin
    rd_val = 32'h00000000;
    unique case (HADDR[7:0])
      ADDR_CTRL: rd_val = ctrl_r;
      ADDR_BAUD: rd_val = baud_r;
      ADDR_TXBUF: rd_val = {24'h000000, buf_r};
      ADDR_STATUS: begin
        rd_val[STAT_READY_BIT] = ~buf_full_r;
        rd_val[STAT_BUSY_BIT] = gen_run;
        rd_val[STAT_MON_LSB +: 8] = mon_r;
      end
      default: rd_val = 32'h00000000;
    endcase
  end

  // Read data and response registers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      hrdata_r <= 32'h00000000;
      hreadyout_r <= 1'b0;
      hresp_r <= 1'b0;
    end else begin
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0; // Every transfer answers OKAY
      if (addr_ok && !HWRITE) hrdata_r <= rd_val;
    end
  end

  // Outputs
  assign HRDATA = hrdata_r;
  assign HREADYOUT = hreadyout_r;
  assign HRESP = hresp_r;
  assign TXD = txd_r;
endmodule
`default_nettype wire

// ### ubg_vote.sv
`timescale 1ns/1ps
`default_nettype none
module ubg_vote
  import ubg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Synchronised line and strobes
  input wire logic line,
  input wire ubg_pkg::ubg_smp_t smp,
  // Voted bit
  output logic voted,
  output logic valid
);
  logic s0_r;
  logic s1_r;

  // Hold first two samples
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s0_r <= 1'b1;
      s1_r <= 1'b1;
    end else begin
      if (smp.first) s0_r <= line;
      if (smp.mid) s1_r <= line;
    end
  end

  // Decide the bit on the third sample
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      voted <= 1'b1;
      valid <= 1'b0;
    end else begin
      valid <= smp.last;
      if (smp.last) voted <= ubg_major(s0_r, s1_r, line);
    end
  end
endmodule
`default_nettype wire
